// >>> cfgl_fetch_if.sv
// Carrier between the register owner and the flash word reader.
// Assumes both ends run on the same clock.
`timescale 1ns/100ps
interface cfgl_fetch_if;
    logic        restart;    // Pulse: begin a fresh load
    logic        word_valid; // Pulse: a word has arrived
    logic [1:0]  word_idx;   // Index of the arriving word
    logic [23:0] word_data;  // Arriving word
    logic        done;       // Pulse: all words delivered

    // Reader side
    modport reader (input restart, output word_valid, word_idx,
                    output word_data, done);
    // Register owner side
    modport owner  (output restart, input word_valid, word_idx,
                    input word_data, done);
endinterface

// >>> cfgl_flash_model.sv
// Flash array model holding the three configuration words.
// Assumes the loader holds read and address until valid is seen.
`timescale 1ns/100ps
module cfgl_flash_model
    import cfgl_pkg::*;
(
    // Clock and reset
    input  wire logic        clk_i,
    input  wire logic        rst_n_i,
    // Read port from the loader
    input  wire logic        rd_i,
    input  wire logic [23:0] addr_i,
    output logic [23:0]      data_o,
    output logic             valid_o,
    // Answer delay and stored words
    input  wire logic [3:0]  lat_i,
    input  wire logic [23:0] word1_i,
    input  wire logic [23:0] word2_i,
    input  wire logic [23:0] word3_i
);
    logic [3:0] cnt_q;  // Cycles waited on the current read

    // Answer after lat_i cycles; data toggles whenever not answering
    // so a loader sampling out of turn never sees stale good data
    always_ff @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            cnt_q   <= 4'h0;
            valid_o <= 1'b0;
            data_o  <= 24'h000000;
        end
        else
        begin
            valid_o <= 1'b0;
            data_o  <= ~data_o;
            if (rd_i && !valid_o && cnt_q == lat_i)
            begin
                cnt_q   <= 4'h0;
                valid_o <= 1'b1;
                // Words sit at the top of flash, two apart
                if (addr_i == 24'h00abfe)
                    data_o <= word1_i;
                else if (addr_i == 24'h00abfc)
                    data_o <= word2_i;
                else if (addr_i == 24'h00abfa)
                    data_o <= word3_i;
            end
            else if (rd_i && !valid_o)
                cnt_q <= cnt_q + 4'h1;
        end
    end
endmodule

// >>> cfgl_flash_reader.sv
// Reads the packed configuration words from the top of flash.
// Assumes the flash answers on the same clock with a valid strobe.
`timescale 1ns/100ps
module cfgl_flash_reader
    import cfgl_pkg::*;
(
    // Clock and reset
    input  wire logic        clk_i,
    input  wire logic        rst_n_i,
    // Carrier to the register owner
    cfgl_fetch_if.reader     fetch,
    // Flash read port
    output logic             flash_rd_o,
    output logic [23:0]      flash_addr_o,
    input  wire logic [23:0] flash_data_i,
    input  wire logic        flash_valid_i
);

    cfgl_state_e state_q;    // Sequencer state
    logic [1:0]  idx_q;      // Word being fetched

    // Sequencer: reset itself starts a load, so every reset reloads
    always_ff @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            state_q <= CFGL_ST_ISSUE;
            idx_q   <= 2'h0;
        end
        else if (fetch.restart)
        begin
            // Any later reset source restarts from the first word
            state_q <= CFGL_ST_ISSUE;
            idx_q   <= 2'h0;
        end
        else
        begin
            case (state_q)
                CFGL_ST_ISSUE: state_q <= CFGL_ST_WAIT;
                CFGL_ST_WAIT:
                begin
                    if (flash_valid_i)
                    begin
                        // Last word ends the load
                        if (idx_q == 2'(CFGL_NUM_WORDS - 1))
                            state_q <= CFGL_ST_DONE;
                        else
                        begin
                            state_q <= CFGL_ST_ISSUE;
                            idx_q   <= idx_q + 2'h1;
                        end
                    end
                end
                CFGL_ST_DONE:  state_q <= CFGL_ST_DONE;
                default:       state_q <= CFGL_ST_DONE;
            endcase
        end
    end

    // Flash strobe and address; word one at the highest address
    always_ff @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            flash_rd_o   <= 1'b0;
            flash_addr_o <= 24'h000000;
        end
        else if (fetch.restart)
            flash_rd_o   <= 1'b0;
        else if (state_q == CFGL_ST_ISSUE)
        begin
            flash_rd_o   <= 1'b1;
            flash_addr_o <= CFGL_FLASH_TOP
                            - (CFGL_FLASH_STEP * {22'h0, idx_q});
        end
        else if (flash_valid_i)
            flash_rd_o   <= 1'b0;
    end

    // Word delivery and completion pulses
    always_ff @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            fetch.word_valid <= 1'b0;
            fetch.word_idx   <= 2'h0;
            fetch.word_data  <= 24'h000000;
            fetch.done       <= 1'b0;
        end
        else
        begin
            fetch.word_valid <= 1'b0;
            fetch.done       <= 1'b0;
            if (!fetch.restart && state_q == CFGL_ST_WAIT
                && flash_valid_i)
            begin
                fetch.word_valid <= 1'b1;
                fetch.word_idx   <= idx_q;
                fetch.word_data  <= flash_data_i;
                fetch.done       <= (idx_q == 2'(CFGL_NUM_WORDS - 1));
            end
        end
    end

endmodule

// >>> cfgl_loader.sv
// Configuration word loader: copies the flash configuration words into
// volatile registers on every reset, decodes word one, and serves
// table reads and writes of the configuration space.
// Assumes flash, table port and reset requests share CLK_I; the
// boundary-scan programming flag arrives from a pin.
//
// Summary of operation
// - Programmed bit reads zero, unprogrammed reads one
// - Config registers from F80000h, table access only
// - Volatile registers sourced from top flash words
// - Every reset reloads the configuration words
// - Upper byte and bit 5 read one, writes ignored
// - Erased words load zero, enabling code protection
// - Fields program-once, default one; bit 15 unknown
// - Bit 14 enables scan port, not scan-writable
// - Bit 13 clear enables read protection
// - Bit 12 clear disables program memory writes
// - Bit 11 clear resets into debug mode
// - Bits 9-8 pick emulator pin pair; 00 reserved
// - Bit 7 set enables the watchdog
// - Bit 6 clear selects windowed watchdog
// - Bit 4 picks prescale 1:128 or 1:32
// - Bits 3-0 pick power-of-two postscale
`timescale 1ns/100ps
module cfgl_loader
    import cfgl_pkg::*;
(
    // Clock and reset
    input  wire logic        CLK_I,
    input  wire logic        RST_N_I,
    // Other device reset sources, one-cycle pulse
    input  wire logic        DEV_RST_REQ_I,
    // Flash read port
    output logic             FLASH_RD_O,
    output logic [23:0]      FLASH_ADDR_O,
    input  wire logic [23:0] FLASH_DATA_I,
    input  wire logic        FLASH_VALID_I,
    // Table read and write port
    input  wire logic        TBL_REQ_I,
    input  wire logic        TBL_WR_I,
    input  wire logic [23:0] TBL_ADDR_I,
    input  wire logic [23:0] TBL_WDATA_I,
    output logic             TBL_ACK_O,
    output logic [23:0]      TBL_RDATA_O,
    // Programming path flag from a pin
    input  wire logic        SCAN_PROG_ACTIVE_I,
    // Reset hold towards the core
    output logic             CORE_RST_HOLD_O,
    // Decoded word one
    output logic             SCAN_PORT_ENABLE_O,
    output logic             READ_PROTECT_ON_O,
    output logic             PROG_WRITE_ALLOW_O,
    output logic             DEBUG_ENTRY_O,
    output logic             PROGRAM_PIN_PAIR_ONE_O,
    output logic             PROGRAM_PIN_PAIR_TWO_O,
    output logic             PROGRAM_PIN_PAIR_THREE_O,
    output logic             PIN_PAIR_RESERVED_O,
    output logic             WATCHDOG_ENABLE_O,
    output logic             WATCHDOG_WINDOWED_O,
    output logic             WATCHDOG_PRESCALE_128_O,
    output logic [15:0]      WATCHDOG_POSTSCALE_O
);

    // Volatile configuration registers, one per flash word
    logic [23:0] cfg_q [CFGL_NUM_WORDS];
    // Carrier to the flash word reader
    cfgl_fetch_if fetch ();
    // Scan programming flag synchroniser
    logic        scan_meta_q;
    logic        scan_sync_q;
    // Visible word one, fixed bits forced
    logic [23:0] word_one;

    // Address decode shared by table read and write
    function automatic logic [2:0] cfg_slot(input logic [23:0] addr);
        logic [2:0] hit;
        hit = 3'h0;
        if (addr == CFGL_CW1_ADDR)
            hit = 3'h1;
        else if (addr == CFGL_CW2_ADDR)
            hit = 3'h2;
        else if (addr == CFGL_CW3_ADDR)
            hit = 3'h4;
        return hit;
    endfunction

    // Bits that read as one in a given word
    function automatic logic [23:0] ones_mask(input int idx);
        logic [23:0] m;
        m = CFGL_CW3_ONES;
        if (idx == 0)
            m = CFGL_CW1_ONES;
        else if (idx == 1)
            m = CFGL_CW2_ONES;
        return m;
    endfunction

    // Program-once bits of a given word
    function automatic logic [23:0] po_mask(input int idx);
        logic [23:0] m;
        m = CFGL_CW3_PO;
        if (idx == 0)
            m = CFGL_CW1_PO;
        else if (idx == 1)
            m = CFGL_CW2_PO;
        return m;
    endfunction

    // Restart the load on any other reset source
    assign fetch.restart = DEV_RST_REQ_I;

    // The flash word reader
    cfgl_flash_reader u_reader
    (
        .clk_i         (CLK_I),
        .rst_n_i       (RST_N_I),
        .fetch         (fetch),
        .flash_rd_o    (FLASH_RD_O),
        .flash_addr_o  (FLASH_ADDR_O),
        .flash_data_i  (FLASH_DATA_I),
        .flash_valid_i (FLASH_VALID_I)
    );

    // Two-stage synchroniser; the flag comes straight from a pin
    always_ff @(posedge CLK_I or negedge RST_N_I)
    begin
        if (!RST_N_I)
        begin
            scan_meta_q <= 1'b0;
            scan_sync_q <= 1'b0;
        end
        else
        begin
            scan_meta_q <= SCAN_PROG_ACTIVE_I;
            scan_sync_q <= scan_meta_q;
        end
    end

    // Core reset hold: released only by the reader's done pulse
    always_ff @(posedge CLK_I or negedge RST_N_I)
    begin
        if (!RST_N_I)
            CORE_RST_HOLD_O <= 1'b1;
        else if (DEV_RST_REQ_I)
            CORE_RST_HOLD_O <= 1'b1;
        else if (fetch.done)
            CORE_RST_HOLD_O <= 1'b0;
    end

    // Configuration registers, one process per word
    generate
        for (genvar g = 0; g < CFGL_NUM_WORDS; g++)
        begin : g_word
            always_ff @(posedge CLK_I or negedge RST_N_I)
            begin
                if (!RST_N_I)
                    // Unprogrammed value until the load fills it
                    cfg_q[g] <= CFGL_UNPROG;
                else if (fetch.word_valid
                         && fetch.word_idx == 2'(g))
                    // Erased flash loads zeros unchanged
                    cfg_q[g] <= fetch.word_data;
                else if (TBL_REQ_I && TBL_WR_I && !CORE_RST_HOLD_O
                         && (cfg_slot(TBL_ADDR_I) & (3'h1 << g)) != 3'h0)
                begin
                    // Program-once: a write can only clear bits,
                    // so ones written have no effect
                    if (g == 0 && scan_sync_q)
                        cfg_q[g] <= cfg_q[g] & (TBL_WDATA_I
                            | ~po_mask(g)
                            | (24'h1 << CFGL_B_SCAN));
                    else
                        cfg_q[g] <= cfg_q[g]
                            & (TBL_WDATA_I | ~po_mask(g));
                end
            end
        end
    endgenerate

    // Word one as seen by software and decode
    assign word_one = cfg_q[0] | CFGL_CW1_ONES;

    // Table answer; refused without acknowledge while loading
    always_ff @(posedge CLK_I or negedge RST_N_I)
    begin
        if (!RST_N_I)
        begin
            TBL_ACK_O   <= 1'b0;
            TBL_RDATA_O <= 24'h000000;
        end
        else
        begin
            TBL_ACK_O <= TBL_REQ_I && !CORE_RST_HOLD_O;
            if (TBL_REQ_I && !TBL_WR_I && !CORE_RST_HOLD_O)
            begin
                // Unmapped space reads zero
                TBL_RDATA_O <= 24'h000000;
                for (int i = 0; i < CFGL_NUM_WORDS; i++)
                    if ((cfg_slot(TBL_ADDR_I) & (3'h1 << i)) != 3'h0)
                        TBL_RDATA_O <= cfg_q[i] | ones_mask(i);
            end
        end
    end

    // Scan port, protection and debug entry decode
    always_ff @(posedge CLK_I or negedge RST_N_I)
    begin
        if (!RST_N_I)
        begin
            SCAN_PORT_ENABLE_O <= 1'b1;
            READ_PROTECT_ON_O  <= 1'b0;
            PROG_WRITE_ALLOW_O <= 1'b1;
            DEBUG_ENTRY_O      <= 1'b0;
        end
        else
        begin
            SCAN_PORT_ENABLE_O <= word_one[CFGL_B_SCAN];
            // Zero, as left by an erase, protects everything
            READ_PROTECT_ON_O  <= ~word_one[CFGL_B_RDPROT];
            // Set is taken as permitting writes
            PROG_WRITE_ALLOW_O <= word_one[CFGL_B_WRPROT];
            DEBUG_ENTRY_O      <= ~word_one[CFGL_B_DEBUG];
        end
    end

    // Emulator pin pair decode; reserved code selects no pair
    always_ff @(posedge CLK_I or negedge RST_N_I)
    begin
        if (!RST_N_I)
        begin
            PROGRAM_PIN_PAIR_ONE_O   <= 1'b1;
            PROGRAM_PIN_PAIR_TWO_O   <= 1'b0;
            PROGRAM_PIN_PAIR_THREE_O <= 1'b0;
            PIN_PAIR_RESERVED_O      <= 1'b0;
        end
        else
        begin
            PROGRAM_PIN_PAIR_ONE_O   <= word_one[CFGL_B_PAIR_HI:
                CFGL_B_PAIR_LO] == CFGL_PAIR_ONE;
            PROGRAM_PIN_PAIR_TWO_O   <= word_one[CFGL_B_PAIR_HI:
                CFGL_B_PAIR_LO] == CFGL_PAIR_TWO;
            PROGRAM_PIN_PAIR_THREE_O <= word_one[CFGL_B_PAIR_HI:
                CFGL_B_PAIR_LO] == CFGL_PAIR_THREE;
            PIN_PAIR_RESERVED_O      <= word_one[CFGL_B_PAIR_HI:
                CFGL_B_PAIR_LO] == 2'h0;
        end
    end

    // Watchdog decode
    always_ff @(posedge CLK_I or negedge RST_N_I)
    begin
        if (!RST_N_I)
        begin
            WATCHDOG_ENABLE_O       <= 1'b1;
            WATCHDOG_WINDOWED_O     <= 1'b0;
            WATCHDOG_PRESCALE_128_O <= 1'b1;
            WATCHDOG_POSTSCALE_O    <= 16'h8000;
        end
        else
        begin
            WATCHDOG_ENABLE_O       <= word_one[CFGL_B_WDT_EN];
            // Window mode only means something with the dog on
            WATCHDOG_WINDOWED_O     <= word_one[CFGL_B_WDT_EN]
                                       & ~word_one[CFGL_B_WIN_OFF];
            WATCHDOG_PRESCALE_128_O <= word_one[CFGL_B_PRESCALE];
            // One-hot divide ratio: 1 << code
            WATCHDOG_POSTSCALE_O    <= 16'h0001
                << word_one[CFGL_B_POST_HI:0];
        end
    end

endmodule

// >>> cfgl_loader_properties.sv
// Port checker for the configuration word loader.
// Assumes it is bound into cfgl_loader on the single clock.
`timescale 1ns/100ps
module cfgl_loader_properties
(
    // Clock, reset, reload
    input wire logic        CLK_I,
    input wire logic        RST_N_I,
    input wire logic        DEV_RST_REQ_I,
    // Flash and table ports
    input wire logic        FLASH_RD_O,
    input wire logic [23:0] FLASH_ADDR_O,
    input wire logic        FLASH_VALID_I,
    input wire logic        TBL_REQ_I,
    input wire logic        TBL_WR_I,
    input wire logic [23:0] TBL_ADDR_I,
    input wire logic        TBL_ACK_O,
    input wire logic [23:0] TBL_RDATA_O,
    input wire logic        CORE_RST_HOLD_O,
    // Decode outputs
    input wire logic [3:0]  PAIRS,
    input wire logic        WATCHDOG_ENABLE_O,
    input wire logic        WATCHDOG_WINDOWED_O,
    input wire logic [15:0] WATCHDOG_POSTSCALE_O
);
    default clocking cb @(posedge CLK_I); endclocking
    default disable iff (!RST_N_I);

    chk_ack_next: assert property (
        TBL_REQ_I && !CORE_RST_HOLD_O |=> TBL_ACK_O)
        else $error("table ack missing");
    chk_ack_cause: assert property (
        TBL_ACK_O |-> $past(TBL_REQ_I) && !$past(CORE_RST_HOLD_O))
        else $error("table ack without accepted request");
    chk_rd_stands: assert property (
        FLASH_RD_O && !FLASH_VALID_I && !DEV_RST_REQ_I
        |=> FLASH_RD_O && $stable(FLASH_ADDR_O))
        else $error("flash read dropped early");
    chk_rd_gap: assert property (
        FLASH_RD_O && FLASH_VALID_I |=> !FLASH_RD_O)
        else $error("no idle cycle between reads");
    chk_rd_addr: assert property (
        FLASH_RD_O |-> FLASH_ADDR_O inside
        {24'h00abfe, 24'h00abfc, 24'h00abfa})
        else $error("flash read outside word area");
    chk_hold_load: assert property (
        FLASH_RD_O |-> CORE_RST_HOLD_O)
        else $error("core released during load");
    chk_reload_hold: assert property (
        DEV_RST_REQ_I |=> ##[0:2] CORE_RST_HOLD_O)
        else $error("reload did not hold core");
    chk_win_gate: assert property (
        WATCHDOG_WINDOWED_O |-> WATCHDOG_ENABLE_O)
        else $error("windowed without enable");
    chk_pair_one: assert property ($onehot(PAIRS))
        else $error("pin pair decode not one-hot");
    chk_post_pow: assert property ($onehot(WATCHDOG_POSTSCALE_O))
        else $error("postscale not a power of two");
    chk_upper_ones: assert property (
        TBL_ACK_O && !$past(TBL_WR_I) && $past(TBL_ADDR_I) == 24'hf80000
        |-> TBL_RDATA_O[23:16] == 8'hff && TBL_RDATA_O[5])
        else $error("unimplemented bits not read as one");

    // Main scenarios
    cov_reload: cover property (DEV_RST_REQ_I);
    cov_write: cover property (TBL_REQ_I && TBL_WR_I && !CORE_RST_HOLD_O);
    cov_refused: cover property (TBL_REQ_I && CORE_RST_HOLD_O);
endmodule

bind cfgl_loader cfgl_loader_properties u_props (
    .CLK_I(CLK_I), .RST_N_I(RST_N_I), .DEV_RST_REQ_I(DEV_RST_REQ_I),
    .FLASH_RD_O(FLASH_RD_O), .FLASH_ADDR_O(FLASH_ADDR_O),
    .FLASH_VALID_I(FLASH_VALID_I), .TBL_REQ_I(TBL_REQ_I),
    .TBL_WR_I(TBL_WR_I), .TBL_ADDR_I(TBL_ADDR_I), .TBL_ACK_O(TBL_ACK_O),
    .TBL_RDATA_O(TBL_RDATA_O), .CORE_RST_HOLD_O(CORE_RST_HOLD_O),
    .PAIRS({PROGRAM_PIN_PAIR_ONE_O, PROGRAM_PIN_PAIR_TWO_O,
            PROGRAM_PIN_PAIR_THREE_O, PIN_PAIR_RESERVED_O}),
    .WATCHDOG_ENABLE_O(WATCHDOG_ENABLE_O),
    .WATCHDOG_WINDOWED_O(WATCHDOG_WINDOWED_O),
    .WATCHDOG_POSTSCALE_O(WATCHDOG_POSTSCALE_O));

// >>> cfgl_pkg.sv
// Constants shared by the configuration word loader files.
// Assumes a 24-bit flash word and a 24-bit table address space.
package cfgl_pkg;

    // Word and address widths
    localparam int          CFGL_WORD_W      = 24;
    localparam int          CFGL_ADDR_W      = 24;
    localparam int          CFGL_NUM_WORDS   = 3;

    // Table addresses of the volatile configuration registers
    localparam logic [23:0] CFGL_SPACE_BASE  = 24'h800000;
    localparam logic [23:0] CFGL_CW1_ADDR    = 24'hf80000;
    localparam logic [23:0] CFGL_CW2_ADDR    = 24'hf80002;
    localparam logic [23:0] CFGL_CW3_ADDR    = 24'hf80004;

    // Flash address of the first word; later words sit 2 below each
    localparam logic [23:0] CFGL_FLASH_TOP   = 24'h00abfe;
    localparam logic [23:0] CFGL_FLASH_STEP  = 24'h000002;

    // Unprogrammed value of every word
    localparam logic [23:0] CFGL_UNPROG      = 24'hffffff;

    // Bits that read as one whatever is stored
    localparam logic [23:0] CFGL_CW1_ONES    = 24'hff0020;
    localparam logic [23:0] CFGL_CW2_ONES    = 24'hff0000;
    localparam logic [23:0] CFGL_CW3_ONES    = 24'hff1f00;

    // Program-once bits a table write may clear
    localparam logic [23:0] CFGL_CW1_PO      = 24'h007bdf;
    localparam logic [23:0] CFGL_CW2_PO      = 24'h00fffb;
    localparam logic [23:0] CFGL_CW3_PO      = 24'h00e0ff;

    // Field positions of word one
    localparam int          CFGL_B_SCAN      = 14;
    localparam int          CFGL_B_RDPROT    = 13;
    localparam int          CFGL_B_WRPROT    = 12;
    localparam int          CFGL_B_DEBUG     = 11;
    localparam int          CFGL_B_PAIR_HI   = 9;
    localparam int          CFGL_B_PAIR_LO   = 8;
    localparam int          CFGL_B_WDT_EN    = 7;
    localparam int          CFGL_B_WIN_OFF   = 6;
    localparam int          CFGL_B_PRESCALE  = 4;
    localparam int          CFGL_B_POST_HI   = 3;

    // Emulator pin pair codes
    localparam logic [1:0]  CFGL_PAIR_ONE    = 2'h3;
    localparam logic [1:0]  CFGL_PAIR_TWO    = 2'h2;
    localparam logic [1:0]  CFGL_PAIR_THREE  = 2'h1;

    // Loader states
    typedef enum logic [1:0]
    {
        CFGL_ST_ISSUE = 2'b00,
        CFGL_ST_WAIT  = 2'b01,
        CFGL_ST_DONE  = 2'b10
    } cfgl_state_e;

endpackage

// >>> flash_config_word_loader_tb_top.sv
// Self-checking bench for the configuration word loader.
// Assumes the flash model answers the loader's read port.
`timescale 1ns/100ps
`define CHK(n, g, e) begin samples_checked++; if ((g) !== (e)) begin \
    miscompares++; $display("mismatch %s exp %h got %h", n, e, g); end end
module flash_config_word_loader_tb_top;
    import cfgl_pkg::*;
    // One table read: address and the data it should return
    typedef struct packed {logic [23:0] a; logic [23:0] e;} cfgl_row_s;
    logic        CLK_I = 1'b0, RST_N_I = 1'b0, DEV_RST_REQ_I = 1'b0;
    logic        TBL_REQ_I = 1'b0, TBL_WR_I = 1'b0;
    logic        SCAN_PROG_ACTIVE_I = 1'b0;
    logic [23:0] TBL_ADDR_I = 24'h000000, TBL_WDATA_I = 24'h000000;
    logic [23:0] w1 = 24'h005f85, w2 = 24'h123456, w3 = 24'h00abcd;
    logic [3:0]  lat = 4'h0;          // Flash answer delay
    logic        FLASH_RD_O, FLASH_VALID_I, TBL_ACK_O, CORE_RST_HOLD_O;
    logic [23:0] FLASH_ADDR_O, FLASH_DATA_I, TBL_RDATA_O, rd;
    logic [26:0] dec;                 // Decode outputs in port order
    int          miscompares = 0, samples_checked = 0, cycles = 0;
    cfgl_row_s   rows [5] = '{'{CFGL_CW1_ADDR, 24'hff5fa5},
        '{CFGL_CW2_ADDR, 24'hff3456}, '{CFGL_CW3_ADDR, 24'hffbfcd},
        '{24'hf80006, 24'h000000}, '{CFGL_SPACE_BASE, 24'h000000}};

    always #5 CLK_I = ~CLK_I;

    cfgl_loader dut_u (
        .CLK_I(CLK_I), .RST_N_I(RST_N_I), .DEV_RST_REQ_I(DEV_RST_REQ_I),
        .FLASH_RD_O(FLASH_RD_O), .FLASH_ADDR_O(FLASH_ADDR_O),
        .FLASH_DATA_I(FLASH_DATA_I), .FLASH_VALID_I(FLASH_VALID_I),
        .TBL_REQ_I(TBL_REQ_I), .TBL_WR_I(TBL_WR_I), .TBL_ADDR_I(TBL_ADDR_I),
        .TBL_WDATA_I(TBL_WDATA_I), .TBL_ACK_O(TBL_ACK_O),
        .TBL_RDATA_O(TBL_RDATA_O), .SCAN_PROG_ACTIVE_I(SCAN_PROG_ACTIVE_I),
        .CORE_RST_HOLD_O(CORE_RST_HOLD_O), .SCAN_PORT_ENABLE_O(dec[26]),
        .READ_PROTECT_ON_O(dec[25]), .PROG_WRITE_ALLOW_O(dec[24]),
        .DEBUG_ENTRY_O(dec[23]), .PROGRAM_PIN_PAIR_ONE_O(dec[22]),
        .PROGRAM_PIN_PAIR_TWO_O(dec[21]), .PROGRAM_PIN_PAIR_THREE_O(dec[20]),
        .PIN_PAIR_RESERVED_O(dec[19]), .WATCHDOG_ENABLE_O(dec[18]),
        .WATCHDOG_WINDOWED_O(dec[17]), .WATCHDOG_PRESCALE_128_O(dec[16]),
        .WATCHDOG_POSTSCALE_O(dec[15:0]));

    cfgl_flash_model u_flash (
        .clk_i(CLK_I), .rst_n_i(RST_N_I), .rd_i(FLASH_RD_O),
        .addr_i(FLASH_ADDR_O), .data_o(FLASH_DATA_I),
        .valid_o(FLASH_VALID_I), .lat_i(lat), .word1_i(w1),
        .word2_i(w2), .word3_i(w3));

    // Verdict and end of run, reached from the end or the timeout
    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", samples_checked, miscompares);
        if (miscompares == 0 && samples_checked > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask

    // A hang is cut off well beyond the fewer than one hundred cycles needed
    always @(posedge CLK_I)
    begin
        cycles++;
        if (cycles == 5000)
        begin
            miscompares++;
            tally_and_finish();
        end
    end

    // One table access: request for one cycle, ack the next
    task automatic tbl(input logic wr, input logic [23:0] a, d);
        @(negedge CLK_I);
        TBL_REQ_I = 1'b1;
        TBL_WR_I = wr;
        TBL_ADDR_I = a;
        TBL_WDATA_I = d;
        @(negedge CLK_I);
        TBL_REQ_I = 1'b0;
        `CHK("ack", TBL_ACK_O, 1'b1)
        rd = TBL_RDATA_O;
    endtask

    // Bounded wait for the core hold to drop after a load
    task automatic wait_load();
        int n;
        n = 0;
        while (CORE_RST_HOLD_O !== 1'b0 && n < 300)
        begin
            @(negedge CLK_I);
            n++;
        end
        `CHK("hold", CORE_RST_HOLD_O, 1'b0)
        @(negedge CLK_I);
    endtask

    initial
    begin
        repeat (4) @(posedge CLK_I);
        @(negedge CLK_I);
        `CHK("reset decode", dec, 27'h5458000)
        `CHK("reset hold", CORE_RST_HOLD_O, 1'b1)
        RST_N_I = 1'b1;
        wait_load();
        `CHK("flags", dec[26:16], 11'h746)
        `CHK("watchdog", dec[15:0], 16'h0020)
        $display("test load done");
        foreach (rows[i])
        begin
            tbl(1'b0, rows[i].a, 24'h000000);
            `CHK("read", rd, rows[i].e)
        end
        $display("test table reads done");
        // Scan-port bit must not change while programming over scan
        SCAN_PROG_ACTIVE_I = 1'b1;
        repeat (3) @(negedge CLK_I);
        tbl(1'b1, CFGL_CW1_ADDR, 24'hffbfff);
        tbl(1'b0, CFGL_CW1_ADDR, 24'h000000);
        `CHK("scan locked", rd, 24'hff5fa5)
        SCAN_PROG_ACTIVE_I = 1'b0;
        repeat (3) @(negedge CLK_I);
        tbl(1'b1, CFGL_CW1_ADDR, 24'h00bd5f);
        tbl(1'b1, CFGL_CW1_ADDR, 24'hffffff);
        tbl(1'b0, CFGL_CW1_ADDR, 24'h000000);
        `CHK("clear only", rd, 24'hff1d25)
        @(negedge CLK_I);
        `CHK("cleared flags", dec[26:16], 11'h310)
        $display("test writes done");
        // Reload from a slow flash picks up a changed stored word
        lat = 4'h3;
        w1 = 24'h005e85;
        DEV_RST_REQ_I = 1'b1;
        @(negedge CLK_I);
        DEV_RST_REQ_I = 1'b0;
        repeat (3) @(negedge CLK_I);
        `CHK("reload hold", CORE_RST_HOLD_O, 1'b1)
        wait_load();
        tbl(1'b0, CFGL_CW1_ADDR, 24'h000000);
        `CHK("reloaded", rd, 24'hff5ea5)
        `CHK("reload pair", dec[22:19], 4'h4)
        $display("test reload done");
        // Erased words, fresh reset, request refused during load
        w1 = 24'h000000;
        w2 = 24'h000000;
        w3 = 24'h000000;
        lat = 4'h0;
        RST_N_I = 1'b0;
        @(negedge CLK_I);
        RST_N_I = 1'b1;
        TBL_REQ_I = 1'b1;
        TBL_ADDR_I = CFGL_CW1_ADDR;
        TBL_WR_I = 1'b0;
        @(negedge CLK_I);
        `CHK("refused", TBL_ACK_O, 1'b0)
        `CHK("refused data", TBL_RDATA_O, 24'h000000)
        TBL_REQ_I = 1'b0;
        wait_load();
        `CHK("erased", dec, 27'h2880001)
        tbl(1'b0, CFGL_CW1_ADDR, 24'h000000);
        `CHK("erased read", rd, 24'hff0020)
        $display("test erase done");
        tally_and_finish();
    end
endmodule
